// File: common/sar_adc_map.svh
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// ----------------------------------------------------------------
// register offsets on the cpu memory bus
// ----------------------------------------------------------------
`define OFS_CONVERSION_RESULT 16'hff08
`define OFS_CONVERTER_CONTROL 16'hff28
`define OFS_INPUT_CHANNEL_SELECT 16'hff29
`define OFS_COMPARE_MODE 16'hff2a
`define OFS_COMPARE_THRESHOLD 16'hff2b

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_RUN_BIT 7
`define CTRL_TSEL_MSB 5
`define CTRL_TSEL_LSB 3
`define CTRL_REFEN_BIT 0
`define CHAN_MSB 2
`define CMP_ENABLE_BIT 7
`define CMP_DIRECTION_BIT 6
`define RESULT_PAD_BITS 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CONVERTER_CONTROL 8'h00
`define RST_INPUT_CHANNEL_SELECT 8'h00
`define RST_COMPARE_MODE 8'h00
`define RST_COMPARE_THRESHOLD 8'h00

// ----------------------------------------------------------------
// conversion time in main clock cycles per time-select code
// ----------------------------------------------------------------
`define TSEL_CODE_288 3'h0
`define TSEL_CODE_240 3'h1
`define TSEL_CODE_192 3'h2
`define TSEL_CODE_144 3'h4
`define TSEL_CODE_120 3'h5
`define TSEL_CODE_96 3'h6
`define CONV_CYC_288 9'h120
`define CONV_CYC_240 9'h0f0
`define CONV_CYC_192 9'h0c0
`define CONV_CYC_144 9'h090
`define CONV_CYC_120 9'h078
`define CONV_CYC_96 9'h060

// conversion period split in equal slots: two sampling slots, ten bit trials
`define CONV_SLOTS 4'hc
`define SAMPLE_SLOTS 4'h2
`define LAST_SLOT 4'hb

`endif

// File: common/sar_adc_pkg.sv
package sar_adc_pkg;

    // conversion sequencer states
    typedef enum logic [1:0] {
        st_stopped,
        st_sampling,
        st_trialing
    } conv_state_e;

    typedef logic [9:0] sar_word_t;
    typedef logic [15:0] bus_addr_t;

endpackage

// File: logic/approximation_register.sv
// successive approximation register: one bit trial at a time, msb first
module approximation_register #(
    parameter int WIDTH = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trial_start,
    input wire logic trial_end,
    input wire logic [3:0] bit_idx,
    input wire logic comp_in,
    output logic [WIDTH-1:0] sar_q
);

    logic [WIDTH-1:0] sar_ff;
    logic [WIDTH-1:0] bit_mask;

    // one-hot mask of the bit under trial
    assign bit_mask = WIDTH'(1) << bit_idx;

    // ----------------------------------------------------------------
    // trial update
    // ----------------------------------------------------------------
    // msb trial clears the word, each trial sets its bit and keeps it
    // only if the comparator says input is at or above the tap
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sar_ff <= '0;
        end
        else if (trial_start)
        begin
            if (bit_idx == 4'(WIDTH - 1))
            begin
                sar_ff <= bit_mask;
            end
            else
            begin
                sar_ff <= sar_ff | bit_mask;
            end
        end
        else if (trial_end && !comp_in)
        begin
            sar_ff <= sar_ff & ~bit_mask;
        end
    end

    assign sar_q = sar_ff;

endmodule

// File: logic/sar_adc_control_power_fail.sv
// Notes on behaviour
// - run bit one converts, zero stops
// - time-select code picks conversion cycle count
// - reference-enable bit drives boost reference output
// - run without reference: first result invalid
// - both off stops; reference-only waits idle
// - wait cycle on writes and result read
// - channel register bits 2:0 select input
// - result left-justified, low six bits zero
// - high byte upper eight, low byte two
// - result register has no reset value
// - control or channel write may corrupt result
// - compare enable selects threshold comparison mode
// - direction bit picks at-least or below threshold
// - threshold compared with upper eight result bits
// - compare off: interrupt every conversion, repeat
// - register write aborts, restarts if running
// - clearing run stops immediately, result undefined
`include "sar_adc_map.svh"

module sar_adc_control_power_fail (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_wait,
    input wire logic comp_in,
    output logic [2:0] channel_sel,
    output logic ref_enable,
    output logic sample_hold,
    output logic [9:0] dac_code,
    output logic converter_active,
    output logic conversion_done_irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic run_ff;
    logic [2:0] tsel_ff;
    logic refen_ff;
    logic [2:0] chan_ff;
    logic cmp_en_ff;
    logic cmp_dir_ff;
    logic [7:0] thr_ff;
    logic [15:0] result_ff;
    logic [15:0] rdata_ff;
    logic wait_done_ff;
    logic need_wait;
    logic take;
    logic wr_take;
    logic rd_take;
    logic hit_ctrl;
    logic hit_chan;
    logic hit_mode;
    logic hit_thr;
    logic hit_result;
    logic wr_hit;
    logic nxt_run;
    sar_adc_pkg::conv_state_e state_ff;
    logic [3:0] slot_idx_ff;
    logic [4:0] slot_cnt_ff;
    logic [4:0] slot_len;
    logic slot_end;
    logic conv_done;
    logic load_ff;
    logic irq_ff;
    logic trial_start;
    logic trial_end;
    logic [3:0] bit_idx;
    sar_adc_pkg::sar_word_t sar_q;
    logic [7:0] upper;
    logic cond_met;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // cycles of one conversion for a time-select code; prohibited codes
    // fall back to the longest time
    function automatic logic [8:0] conv_cycles(input logic [2:0] code);
        logic [8:0] cyc;
        cyc = `CONV_CYC_288;
        case (code)
            `TSEL_CODE_288: cyc = `CONV_CYC_288;
            `TSEL_CODE_240: cyc = `CONV_CYC_240;
            `TSEL_CODE_192: cyc = `CONV_CYC_192;
            `TSEL_CODE_144: cyc = `CONV_CYC_144;
            `TSEL_CODE_120: cyc = `CONV_CYC_120;
            `TSEL_CODE_96: cyc = `CONV_CYC_96;
            default: cyc = `CONV_CYC_288;
        endcase
        return cyc;
    endfunction

    // cycles of one slot: a twelfth of the conversion
    function automatic logic [4:0] slot_cycles(input logic [2:0] code);
        logic [8:0] len;
        len = conv_cycles(code) / 9'(`CONV_SLOTS);
        return len[4:0];
    endfunction

    // ----------------------------------------------------------------
    // bus decode and wait insertion
    // ----------------------------------------------------------------
    assign hit_ctrl = (bus_addr == `OFS_CONVERTER_CONTROL);
    assign hit_chan = (bus_addr == `OFS_INPUT_CHANNEL_SELECT);
    assign hit_mode = (bus_addr == `OFS_COMPARE_MODE);
    assign hit_thr = (bus_addr == `OFS_COMPARE_THRESHOLD);
    assign hit_result = (bus_addr == `OFS_CONVERSION_RESULT);

    // one wait cycle on register writes and on result reads
    assign need_wait = (bus_wr && (hit_ctrl || hit_chan || hit_mode || hit_thr)) ||
                       (bus_rd && hit_result);
    assign bus_wait = need_wait && !wait_done_ff;
    assign take = (bus_wr || bus_rd) && !bus_wait;
    assign wr_take = take && bus_wr;
    assign rd_take = take && bus_rd;
    assign wr_hit = wr_take && (hit_ctrl || hit_chan || hit_mode || hit_thr);

    // remembers that the current access has already waited once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_done_ff <= 1'b0;
        end
        else
        begin
            wait_done_ff <= bus_wait;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    // control register: run, time select, reference enable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_ff <= 1'(`RST_CONVERTER_CONTROL >> `CTRL_RUN_BIT);
            tsel_ff <= 3'h0;
            refen_ff <= 1'b0;
        end
        else if (wr_take && hit_ctrl)
        begin
            run_ff <= bus_wdata[`CTRL_RUN_BIT];
            tsel_ff <= bus_wdata[`CTRL_TSEL_MSB:`CTRL_TSEL_LSB];
            refen_ff <= bus_wdata[`CTRL_REFEN_BIT];
        end
    end

    // channel and compare registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_ff <= 3'(`RST_INPUT_CHANNEL_SELECT);
            cmp_en_ff <= 1'b0;
            cmp_dir_ff <= 1'b0;
            thr_ff <= `RST_COMPARE_THRESHOLD;
        end
        else
        begin
            if (wr_take && hit_chan)
            begin
                chan_ff <= bus_wdata[`CHAN_MSB:0];
            end
            if (wr_take && hit_mode)
            begin
                cmp_en_ff <= bus_wdata[`CMP_ENABLE_BIT];
                cmp_dir_ff <= bus_wdata[`CMP_DIRECTION_BIT];
            end
            if (wr_take && hit_thr)
            begin
                thr_ff <= bus_wdata;
            end
        end
    end

    // read data, registered on the accepting edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_ff <= 16'h0000;
        end
        else if (rd_take)
        begin
            if (hit_result)
            begin
                rdata_ff <= result_ff;
            end
            else if (hit_ctrl)
            begin
                rdata_ff <= {8'h00, run_ff, 1'b0, tsel_ff, 2'h0, refen_ff};
            end
            else if (hit_chan)
            begin
                rdata_ff <= {13'h0000, chan_ff};
            end
            else if (hit_mode)
            begin
                rdata_ff <= {8'h00, cmp_en_ff, cmp_dir_ff, 6'h00};
            end
            else if (hit_thr)
            begin
                rdata_ff <= {8'h00, thr_ff};
            end
            else
            begin
                rdata_ff <= 16'h0000; // unmapped reads zero
            end
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    // run value after this edge, so a control write that sets run restarts
    assign nxt_run = (wr_take && hit_ctrl) ? bus_wdata[`CTRL_RUN_BIT] : run_ff;
    assign slot_len = slot_cycles(tsel_ff);
    assign slot_end = (slot_cnt_ff == slot_len - 5'h01);
    assign conv_done = (state_ff == sar_adc_pkg::st_trialing) && slot_end && (slot_idx_ff == `LAST_SLOT);

    // state, slot index and slot counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= sar_adc_pkg::st_stopped;
            slot_idx_ff <= 4'h0;
            slot_cnt_ff <= 5'h00;
        end
        else if (wr_hit)
        begin
            // any register write aborts; restart from the top if running
            state_ff <= nxt_run ? sar_adc_pkg::st_sampling : sar_adc_pkg::st_stopped;
            slot_idx_ff <= 4'h0;
            slot_cnt_ff <= 5'h00;
        end
        else if (!run_ff)
        begin
            state_ff <= sar_adc_pkg::st_stopped;
            slot_idx_ff <= 4'h0;
            slot_cnt_ff <= 5'h00;
        end
        else
        begin
            unique case (state_ff)
                sar_adc_pkg::st_stopped:
                begin
                    state_ff <= sar_adc_pkg::st_sampling;
                end
                sar_adc_pkg::st_sampling, sar_adc_pkg::st_trialing:
                begin
                    if (!slot_end)
                    begin
                        slot_cnt_ff <= slot_cnt_ff + 5'h01;
                    end
                    else if (conv_done)
                    begin
                        // back to back conversions while run stays set
                        state_ff <= sar_adc_pkg::st_sampling;
                        slot_idx_ff <= 4'h0;
                        slot_cnt_ff <= 5'h00;
                    end
                    else
                    begin
                        slot_cnt_ff <= 5'h00;
                        slot_idx_ff <= slot_idx_ff + 4'h1;
                        if (slot_idx_ff == `SAMPLE_SLOTS - 4'h1)
                        begin
                            state_ff <= sar_adc_pkg::st_trialing;
                        end
                    end
                end
            endcase
        end
    end

    // bit trials: set bit at slot start, decide at slot end
    assign bit_idx = `LAST_SLOT - slot_idx_ff;
    assign trial_start = (state_ff == sar_adc_pkg::st_trialing) && (slot_cnt_ff == 5'h00) && run_ff && !wr_hit;
    assign trial_end = (state_ff == sar_adc_pkg::st_trialing) && slot_end && run_ff && !wr_hit;

    approximation_register #(
        .WIDTH(10)
    ) u_sar (
        .clk(clk),
        .rst_n(rst_n),
        .trial_start(trial_start),
        .trial_end(trial_end),
        .bit_idx(bit_idx),
        .comp_in(comp_in),
        .sar_q(sar_q)
    );

    // ----------------------------------------------------------------
    // result load, comparison and interrupt
    // ----------------------------------------------------------------
    // result is loaded one edge after the last trial decided
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_ff <= 1'b0;
        end
        else
        begin
            load_ff <= conv_done && run_ff && !wr_hit;
        end
    end

    // no reset: contents undefined until the first conversion ends; register writes never touch it
    always_ff @(posedge clk)
    begin
        if (load_ff)
        begin
            result_ff <= {sar_q, `RESULT_PAD_BITS'(0)};
        end
    end

    assign upper = sar_q[9:2];
    // at-least when direction is zero, below when one
    assign cond_met = cmp_dir_ff ? (upper < thr_ff) : (upper >= thr_ff);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= load_ff && (!cmp_en_ff || cond_met);
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bus_rdata = rdata_ff;
    assign channel_sel = chan_ff;
    assign ref_enable = refen_ff;
    assign sample_hold = (state_ff == sar_adc_pkg::st_sampling);
    assign dac_code = sar_q;
    assign converter_active = (state_ff != sar_adc_pkg::st_stopped);
    assign conversion_done_irq = irq_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic [8:0] conv_len_ff;

    // cycles since the current conversion started
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_len_ff <= 9'h000;
        end
        else if (wr_hit || conv_done || state_ff == sar_adc_pkg::st_stopped)
        begin
            conv_len_ff <= 9'h000;
        end
        else
        begin
            conv_len_ff <= conv_len_ff + 9'h001;
        end
    end

    a_conv_length:
        assert property (@(posedge clk) disable iff (!rst_n)
            conv_done |-> conv_len_ff == conv_cycles(tsel_ff) - 9'h001)
        else $error("conversion length does not match time select");

    a_stop_no_run:
        assert property (@(posedge clk) disable iff (!rst_n)
            (!run_ff && !wr_hit) |=> state_ff == sar_adc_pkg::st_stopped)
        else $error("converter still active with run cleared");

    a_wait_on_access:
        assert property (@(posedge clk) disable iff (!rst_n)
            (need_wait && !$past(bus_wait)) |-> bus_wait ##1 !bus_wait)
        else $error("wait cycle missing or too long");

    a_abort_restart:
        assert property (@(posedge clk) disable iff (!rst_n)
            (wr_hit && nxt_run) |=> state_ff == sar_adc_pkg::st_sampling && slot_idx_ff == 4'h0
                && slot_cnt_ff == 5'h00)
        else $error("register write did not restart conversion");

    a_result_layout:
        assert property (@(posedge clk) disable iff (!rst_n)
            load_ff |=> result_ff[5:0] == 6'h00 && result_ff[15:6] == $past(sar_q))
        else $error("result not loaded left justified");

    a_irq_plain:
        assert property (@(posedge clk) disable iff (!rst_n)
            (conv_done && run_ff && !wr_hit && !cmp_en_ff) |=> ##1 conversion_done_irq)
        else $error("missing interrupt after plain conversion");

    a_irq_below_only:
        assert property (@(posedge clk) disable iff (!rst_n)
            (load_ff && cmp_en_ff && cmp_dir_ff && sar_q[9:2] >= thr_ff) |=> !conversion_done_irq)
        else $error("interrupt raised although result not below threshold");

    a_irq_at_least:
        assert property (@(posedge clk) disable iff (!rst_n)
            (load_ff && cmp_en_ff && !cmp_dir_ff && sar_q[9:2] >= thr_ff) |=> conversion_done_irq)
        else $error("interrupt missing for result at or above threshold");

    a_stop_no_load:
        assert property (@(posedge clk) disable iff (!rst_n)
            (!run_ff) |=> !load_ff)
        else $error("result loaded after run cleared");

    c_plain_done:
        cover property (@(posedge clk) disable iff (!rst_n) conversion_done_irq && !cmp_en_ff);
    c_compare_below:
        cover property (@(posedge clk) disable iff (!rst_n) conversion_done_irq && cmp_en_ff && cmp_dir_ff);
    c_abort_running:
        cover property (@(posedge clk) disable iff (!rst_n) wr_hit && state_ff == sar_adc_pkg::st_trialing);

endmodule

// File: test/analog_source.sv
// analog inputs with sample-hold and a comparator against the tap code
module analog_source (
    input wire logic clk,
    input wire logic [7:0][9:0] levels,
    input wire logic [2:0] channel_sel,
    input wire logic sample_hold,
    input wire logic [9:0] dac_code,
    output logic comp_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [9:0] held_ff;

    // track the selected input while sampling, hold it during trials
    always_ff @(posedge clk)
    begin
        if (sample_hold)
        begin
            held_ff <= levels[channel_sel];
        end
    end

    // one keeps the trial bit: held input at or above the tap
    assign comp_in = (held_ff >= dac_code);
endmodule

// File: test/test_sar_adc_control_power_fail.sv
`include "sar_adc_map.svh"

module test_sar_adc_control_power_fail;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst_n, bus_wr, bus_rd, bus_wait, comp_in, ref_enable;
    logic sample_hold, converter_active, conversion_done_irq, rb;
    logic [15:0] bus_addr, bus_rdata;
    logic [7:0] bus_wdata, up;
    logic [2:0] channel_sel, ch;
    logic [9:0] dac_code;
    logic [7:0][9:0] levels;
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int cyc [6] = '{288, 240, 192, 144, 120, 96};
    int bad_count, checks, cycles, n, lat;

    sar_adc_control_power_fail i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .bus_addr(bus_addr),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata),
        .bus_wait(bus_wait),
        .comp_in(comp_in),
        .channel_sel(channel_sel),
        .ref_enable(ref_enable),
        .sample_hold(sample_hold),
        .dac_code(dac_code),
        .converter_active(converter_active),
        .conversion_done_irq(conversion_done_irq)
    );

    analog_source i_src (
        .clk(clk),
        .levels(levels),
        .channel_sel(channel_sel),
        .sample_hold(sample_hold),
        .dac_code(dac_code),
        .comp_in(comp_in)
    );

    // ----------------------------------------------------------------
    // clock, timeout and closing report
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // cut a hang short well beyond the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // bus access tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // hold the request until an edge sees no wait, then release
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [15:0] q);
        int waits;
        logic ew;
        waits = 0;
        ew = wr ? (a >= `OFS_CONVERTER_CONTROL && a <= `OFS_COMPARE_THRESHOLD) : (a == `OFS_CONVERSION_RESULT);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= wr;
        bus_rd <= !wr;
        @(negedge clk);
        while (bus_wait === 1'b1 && waits < 8)
        begin
            waits++;
            @(negedge clk);
        end
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        @(negedge clk);
        q = bus_rdata;
        check("wait cycles", {15'h0, ew}, 16'(waits));
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [15:0] q;
        access(1'b1, a, d, q);
    endtask

    task automatic rd(input string name, input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] q;
        access(1'b0, a, 8'h00, q);
        check(name, exp, q);
    endtask

    // cycles until the next completion pulse, 1000 when none comes; returns on a rising edge
    task automatic wait_irq(output int k);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end while (conversion_done_irq !== 1'b1 && k < 1000);
        @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        for (int c = 0; c < 8; c++)
            levels[c] = 10'(c * 113 + 300);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset state and register defaults
        check("converter_active", 16'h0, {15'h0, converter_active});
        rd("control", `OFS_CONVERTER_CONTROL, 16'h0000);
        rd("channel", `OFS_INPUT_CHANNEL_SELECT, 16'h0000);
        rd("mode", `OFS_COMPARE_MODE, 16'h0000);
        rd("threshold", `OFS_COMPARE_THRESHOLD, 16'h0000);
        rd("unmapped", 16'hff00, 16'h0000);
        wr(`OFS_CONVERTER_CONTROL, 8'h01);
        check("ref only enable", 16'h1, {15'h0, ref_enable});
        check("ref only idle", 16'h0, {15'h0, converter_active});
        rd("control back", `OFS_CONVERTER_CONTROL, 16'h0001);
        $display("test reset done");
        // every time code, a different channel each, reference on and off
        for (int i = 0; i < 6; i++)
        begin
            ch = 3'(i + 2);
            rb = i[0];
            // stop with the running code first, then change the code while stopped
            wr(`OFS_CONVERTER_CONTROL, {2'b00, codes[(i + 5) % 6], 3'b000});
            wr(`OFS_CONVERTER_CONTROL, {2'b00, codes[i], 2'b00, rb});
            wr(`OFS_INPUT_CHANNEL_SELECT, {5'h00, ch});
            check("channel_sel", {13'h0, ch}, {13'h0, channel_sel});
            // let the reference settle, 14 us at 100 MHz
            if (rb)
                repeat (1400) @(posedge clk);
            wr(`OFS_CONVERTER_CONTROL, {2'b10, codes[i], 2'b00, rb});
            check("ref_enable", {15'h0, rb}, {15'h0, ref_enable});
            check("running", 16'h1, {15'h0, converter_active});
            check("sample_hold", 16'h1, {15'h0, sample_hold});
            wait_irq(n);
            wait_irq(n);
            check("conversion period", 16'(cyc[i]), 16'(n));
            rd("result", `OFS_CONVERSION_RESULT, {levels[ch], 6'h00});
        end
        $display("test timing done");
        // clearing run mid-conversion stops at once
        wr(`OFS_CONVERTER_CONTROL, 8'h31);
        check("stopped", 16'h0, {15'h0, converter_active});
        wait_irq(n);
        check("no irq when stopped", 16'(1000), 16'(n));
        // a register write mid-conversion restarts from the beginning
        wr(`OFS_CONVERTER_CONTROL, 8'hb1);
        wait_irq(lat);
        check("start latency", 16'(cyc[5] + 1), 16'(lat));
        wait_irq(n);
        repeat (40) @(posedge clk);
        wr(`OFS_COMPARE_THRESHOLD, 8'h00);
        wait_irq(n);
        check("restart latency", 16'(cyc[5] + 1), 16'(n));
        $display("test abort done");
        // threshold compare, both directions, on and just above the boundary
        wr(`OFS_INPUT_CHANNEL_SELECT, 8'h00);
        up = levels[0][9:2];
        for (int j = 0; j < 4; j++)
        begin
            wr(`OFS_CONVERTER_CONTROL, 8'h31);
            wr(`OFS_COMPARE_MODE, j[1] ? 8'hc0 : 8'h80);
            wr(`OFS_COMPARE_THRESHOLD, up + 8'(j[0]));
            wr(`OFS_CONVERTER_CONTROL, 8'hb1);
            wait_irq(n);
            check("compare irq", {15'h0, j[1] == j[0]}, {15'h0, n < 1000});
        end
        rd("mode back", `OFS_COMPARE_MODE, 16'h00c0);
        rd("threshold back", `OFS_COMPARE_THRESHOLD, {8'h00, up + 8'h01});
        $display("test compare done");
        complete_run();
    end
endmodule
